// file: design/fwd_cfg_pkg.sv
// Offsets, field positions, masks and reset values of the forwarding configuration bank
package fwd_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	localparam logic [ADDR_W-1:0] TEST_WORD_OFFSET = 8'h6c;
	localparam logic [ADDR_W-1:0] TIMER_OFFSET = 8'h70;
	localparam logic [ADDR_W-1:0] MODE_OFFSET = 8'h74;

	localparam logic [DATA_W-1:0] TEST_WORD_RESET = 32'h04000800;
	localparam logic [DATA_W-1:0] TIMER_RESET = 32'h80000000;
	localparam logic [DATA_W-1:0] MODE_RESET_BASE = 32'h0a730002;

	localparam logic [DATA_W-1:0] TEST_WORD_IMPL = 32'hffffffff;
	localparam logic [DATA_W-1:0] TEST_WORD_RW = 32'hffffffff;
	localparam logic [DATA_W-1:0] TIMER_IMPL = 32'hffff7fff;
	localparam logic [DATA_W-1:0] TIMER_RW = 32'h7fff1fff;
	localparam logic [DATA_W-1:0] MODE_IMPL = 32'h7fffffff;
	localparam logic [DATA_W-1:0] MODE_RW = 32'h00003f7f;

	localparam int REPLAY_LSB = 0;
	localparam int REPLAY_W = 12;
	localparam int REPLAY_EN_BIT = 12;
	localparam int PM_CAP_DIS_BIT = 13;
	localparam int MSI_CAP_DIS_BIT = 14;
	localparam int ACK_LSB = 16;
	localparam int ACK_W = 14;
	localparam int ACK_EN_BIT = 30;
	localparam int VGA_BIT = 31;

	localparam int STORE_FWD_BIT = 0;
	localparam int CUT_LSB = 1;
	localparam int CUT_W = 2;
	localparam int ARB_BIT = 3;
	localparam int CREDIT_BIT = 4;
	localparam int EGRESS_ORD_BIT = 5;
	localparam int TAG_ORD_BIT = 6;
	localparam int NP_STORE_FWD_BIT = 7;
	localparam int PM_PARAM_LSB = 8;
	localparam int PM_PARAM_W = 6;
	localparam int RX_POL_BIT = 14;
	localparam int CPL_PAR_BIT = 15;
	localparam int DRV_W = 5;
	localparam int DRV_3P5_LSB = 16;
	localparam int DRV_6P0_LSB = 21;
	localparam int DRV_HALF_LSB = 26;

	localparam logic [PM_PARAM_W-1:0] PM_PARAM_RESET = 6'h01;
endpackage : fwd_cfg_pkg

// file: design/preload_if.sv
// Carrier for preload writes from the capture stage to the register bank
`timescale 1ns/10ps
`default_nettype none
interface preload_if;
	import fwd_cfg_pkg::*;
	logic valid;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	modport src (output valid, output addr, output data);
	modport dst (input valid, input addr, input data);
endinterface : preload_if
`default_nettype wire

// file: design/preload_port.sv
// Capture stage for default values delivered by the management port or EEPROM loader
`timescale 1ns/10ps
`default_nettype none
module preload_port
	import fwd_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] data,
	input wire logic done,
	output logic loaded,
	preload_if.src pl
);
	// One stage of registering keeps the loader's timing off the bank's write merge
	always_ff @(posedge clk) begin
		if (rst) begin
			pl.valid <= 1'b0;
			pl.addr <= '0;
			pl.data <= '0;
		end else begin
			pl.valid <= wr;
			pl.addr <= addr;
			pl.data <= data;
		end
	end

	// Loader finished; stays set until the next reset
	always_ff @(posedge clk) begin
		if (rst) begin
			loaded <= 1'b0;
		end else if (done) begin
			loaded <= 1'b1;
		end
	end
endmodule : preload_port
`default_nettype wire

// file: design/switch_forwarding_config.sv
// Forwarding mode and link-layer timer configuration bank of the packet switch
`timescale 1ns/10ps
`default_nettype none
module switch_forwarding_config
	import fwd_cfg_pkg::*;
#(
	parameter logic [PM_PARAM_W-1:0] PM_RESET = PM_PARAM_RESET
)
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [ADDR_W-1:0] CFG_ADDR,
	input wire logic [BE_W-1:0] CFG_BE,
	input wire logic [DATA_W-1:0] CFG_WDATA,
	output logic [DATA_W-1:0] CFG_RDATA,
	output logic CFG_RDVALID,
	input wire logic PRELOAD_WR,
	input wire logic [ADDR_W-1:0] PRELOAD_ADDR,
	input wire logic [DATA_W-1:0] PRELOAD_DATA,
	input wire logic PRELOAD_DONE,
	output logic PRELOAD_LOADED,
	input wire logic [REPLAY_W-1:0] REPLAY_DEFAULT,
	input wire logic [ACK_W-1:0] ACK_DEFAULT,
	output logic [REPLAY_W-1:0] REPLAY_TIMEOUT,
	output logic REPLAY_USER_ACTIVE,
	output logic [ACK_W-1:0] ACK_LATENCY,
	output logic ACK_USER_ACTIVE,
	output logic VGA_DECODE_EN,
	output logic PM_CAP_DISABLE,
	output logic MSI_CAP_DISABLE,
	output logic STORE_FORWARD,
	output logic [CUT_W-1:0] CUT_THRESHOLD,
	output logic ARB_HOLD,
	output logic CREDIT_ALL_TYPES,
	output logic EGRESS_ORDERING,
	output logic CPL_TAG_ORDERING,
	output logic NONPOSTED_STORE_FORWARD,
	output logic [PM_PARAM_W-1:0] PM_CONTROL_PARAM,
	output logic RX_POLARITY_INV_DISABLE,
	output logic CPL_PARITY_DISABLE,
	output logic [DRV_W-1:0] DRV_LVL_3P5,
	output logic [DRV_W-1:0] DRV_LVL_6P0,
	output logic [DRV_W-1:0] DRV_LVL_HALF,
	output logic [DATA_W-1:0] PHY_TEST_WORD
);
	localparam logic [DATA_W-1:0] MODE_RESET =
		MODE_RESET_BASE | (DATA_W'(PM_RESET) << PM_PARAM_LSB);

	preload_if pl ();

	logic [DATA_W-1:0] test_word;
	logic [DATA_W-1:0] timer_word;
	logic [DATA_W-1:0] mode_word;
	logic [DATA_W-1:0] next_test_word;
	logic [DATA_W-1:0] next_timer_word;
	logic [DATA_W-1:0] next_mode_word;
	logic [DATA_W-1:0] cfg_mask;
	logic [DATA_W-1:0] next_rdata;

	preload_port u_preload (
		.clk(SYS_CLK),
		.rst(RESET),
		.wr(PRELOAD_WR),
		.addr(PRELOAD_ADDR),
		.data(PRELOAD_DATA),
		.done(PRELOAD_DONE),
		.loaded(PRELOAD_LOADED),
		.pl(pl.src)
	);

	// Byte enables widened to a bit mask
	function automatic logic [DATA_W-1:0] lane_mask(input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < BE_W; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction : lane_mask

	// Replace only the bits named by mask
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] data,
		input logic [DATA_W-1:0] mask
	);
		return (cur & ~mask) | (data & mask);
	endfunction : merge

	assign cfg_mask = lane_mask(CFG_BE);

	// Preload may set read-only defaults too; software write lands after it,
	// so a same-cycle software write wins on the bits it may touch
	always_comb begin
		next_test_word = test_word;
		if (pl.valid && pl.addr == TEST_WORD_OFFSET) begin
			next_test_word = merge(next_test_word, pl.data, TEST_WORD_IMPL);
		end
		if (CFG_WR && CFG_ADDR == TEST_WORD_OFFSET) begin
			next_test_word = merge(next_test_word, CFG_WDATA, TEST_WORD_RW & cfg_mask);
		end
	end

	always_comb begin
		next_timer_word = timer_word;
		if (pl.valid && pl.addr == TIMER_OFFSET) begin
			next_timer_word = merge(next_timer_word, pl.data, TIMER_IMPL);
		end
		// VGA enable and capability disables stay out of the software mask
		if (CFG_WR && CFG_ADDR == TIMER_OFFSET) begin
			next_timer_word = merge(next_timer_word, CFG_WDATA, TIMER_RW & cfg_mask);
		end
	end

	always_comb begin
		next_mode_word = mode_word;
		if (pl.valid && pl.addr == MODE_OFFSET) begin
			next_mode_word = merge(next_mode_word, pl.data, MODE_IMPL);
		end
		// Non-posted select and driver levels are preload-only
		if (CFG_WR && CFG_ADDR == MODE_OFFSET) begin
			next_mode_word = merge(next_mode_word, CFG_WDATA, MODE_RW & cfg_mask);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			test_word <= TEST_WORD_RESET;
		end else begin
			test_word <= next_test_word;
		end
	end

	// Timer fields and VGA enable reset together
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			timer_word <= TIMER_RESET;
		end else begin
			timer_word <= next_timer_word;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mode_word <= MODE_RESET;
		end else begin
			mode_word <= next_mode_word;
		end
	end

	// Reads return the stored word; reserved bits are never stored
	always_comb begin
		if (CFG_ADDR == TEST_WORD_OFFSET) begin
			next_rdata = test_word & TEST_WORD_IMPL;
		end else if (CFG_ADDR == TIMER_OFFSET) begin
			next_rdata = timer_word & TIMER_IMPL;
		end else if (CFG_ADDR == MODE_OFFSET) begin
			next_rdata = mode_word & MODE_IMPL;
		end else begin
			next_rdata = '0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			CFG_RDATA <= '0;
			CFG_RDVALID <= 1'b0;
		end else begin
			CFG_RDVALID <= CFG_RD;
			if (CFG_RD) begin
				CFG_RDATA <= next_rdata;
			end
		end
	end

	// Link layer sees one value; the internal default covers the disabled case
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			REPLAY_TIMEOUT <= '0;
			REPLAY_USER_ACTIVE <= 1'b0;
		end else begin
			REPLAY_USER_ACTIVE <= timer_word[REPLAY_EN_BIT];
			if (timer_word[REPLAY_EN_BIT]) begin
				REPLAY_TIMEOUT <= timer_word[REPLAY_LSB +: REPLAY_W];
			end else begin
				REPLAY_TIMEOUT <= REPLAY_DEFAULT;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			ACK_LATENCY <= '0;
			ACK_USER_ACTIVE <= 1'b0;
		end else begin
			ACK_USER_ACTIVE <= timer_word[ACK_EN_BIT];
			if (timer_word[ACK_EN_BIT]) begin
				ACK_LATENCY <= timer_word[ACK_LSB +: ACK_W];
			end else begin
				ACK_LATENCY <= ACK_DEFAULT;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			VGA_DECODE_EN <= TIMER_RESET[VGA_BIT];
			PM_CAP_DISABLE <= TIMER_RESET[PM_CAP_DIS_BIT];
			MSI_CAP_DISABLE <= TIMER_RESET[MSI_CAP_DIS_BIT];
		end else begin
			VGA_DECODE_EN <= timer_word[VGA_BIT];
			PM_CAP_DISABLE <= timer_word[PM_CAP_DIS_BIT];
			MSI_CAP_DISABLE <= timer_word[MSI_CAP_DIS_BIT];
		end
	end

	// Forwarding and arbitration controls consumed by the datapath
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			STORE_FORWARD <= MODE_RESET[STORE_FWD_BIT];
			CUT_THRESHOLD <= MODE_RESET[CUT_LSB +: CUT_W];
			NONPOSTED_STORE_FORWARD <= MODE_RESET[NP_STORE_FWD_BIT];
		end else begin
			STORE_FORWARD <= mode_word[STORE_FWD_BIT];
			// Value equals cycles ahead of the packet midpoint
			CUT_THRESHOLD <= mode_word[CUT_LSB +: CUT_W];
			NONPOSTED_STORE_FORWARD <= mode_word[NP_STORE_FWD_BIT];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			ARB_HOLD <= MODE_RESET[ARB_BIT];
			CREDIT_ALL_TYPES <= MODE_RESET[CREDIT_BIT];
		end else begin
			// High holds the grant, low lets the arbiter skip starved ports
			ARB_HOLD <= mode_word[ARB_BIT];
			CREDIT_ALL_TYPES <= mode_word[CREDIT_BIT];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			EGRESS_ORDERING <= MODE_RESET[EGRESS_ORD_BIT];
			CPL_TAG_ORDERING <= MODE_RESET[TAG_ORD_BIT];
		end else begin
			EGRESS_ORDERING <= mode_word[EGRESS_ORD_BIT];
			CPL_TAG_ORDERING <= mode_word[TAG_ORD_BIT];
		end
	end

	// Physical-layer settings are only stored and passed on
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			PM_CONTROL_PARAM <= MODE_RESET[PM_PARAM_LSB +: PM_PARAM_W];
			RX_POLARITY_INV_DISABLE <= MODE_RESET[RX_POL_BIT];
			CPL_PARITY_DISABLE <= MODE_RESET[CPL_PAR_BIT];
		end else begin
			PM_CONTROL_PARAM <= mode_word[PM_PARAM_LSB +: PM_PARAM_W];
			RX_POLARITY_INV_DISABLE <= mode_word[RX_POL_BIT];
			CPL_PARITY_DISABLE <= mode_word[CPL_PAR_BIT];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			DRV_LVL_3P5 <= MODE_RESET[DRV_3P5_LSB +: DRV_W];
			DRV_LVL_6P0 <= MODE_RESET[DRV_6P0_LSB +: DRV_W];
			DRV_LVL_HALF <= MODE_RESET[DRV_HALF_LSB +: DRV_W];
		end else begin
			DRV_LVL_3P5 <= mode_word[DRV_3P5_LSB +: DRV_W];
			DRV_LVL_6P0 <= mode_word[DRV_6P0_LSB +: DRV_W];
			DRV_LVL_HALF <= mode_word[DRV_HALF_LSB +: DRV_W];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			PHY_TEST_WORD <= TEST_WORD_RESET;
		end else begin
			PHY_TEST_WORD <= test_word;
		end
	end
endmodule : switch_forwarding_config
`default_nettype wire

// file: tb/switch_forwarding_config_properties.sv
// Port-level assertions for the forwarding configuration bank
`timescale 1ns/10ps
`default_nettype none
module switch_forwarding_config_properties
	import fwd_cfg_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic CFG_WR,
	input wire logic [ADDR_W-1:0] CFG_ADDR,
	input wire logic [BE_W-1:0] CFG_BE,
	input wire logic [DATA_W-1:0] CFG_WDATA,
	input wire logic PRELOAD_WR,
	input wire logic PRELOAD_DONE,
	input wire logic PRELOAD_LOADED,
	input wire logic [REPLAY_W-1:0] REPLAY_DEFAULT,
	input wire logic [ACK_W-1:0] ACK_DEFAULT,
	input wire logic [REPLAY_W-1:0] REPLAY_TIMEOUT,
	input wire logic REPLAY_USER_ACTIVE,
	input wire logic [ACK_W-1:0] ACK_LATENCY,
	input wire logic ACK_USER_ACTIVE,
	input wire logic VGA_DECODE_EN,
	input wire logic STORE_FORWARD,
	input wire logic [CUT_W-1:0] CUT_THRESHOLD,
	input wire logic ARB_HOLD,
	input wire logic CREDIT_ALL_TYPES,
	input wire logic EGRESS_ORDERING,
	input wire logic CPL_TAG_ORDERING,
	input wire logic NONPOSTED_STORE_FORWARD
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	logic mode_wr;
	logic timer_wr;
	// Writes racing a preload are left out; expected values assume software alone
	assign mode_wr = CFG_WR && CFG_ADDR == MODE_OFFSET && CFG_BE[0] && !PRELOAD_WR;
	assign timer_wr = CFG_WR && CFG_ADDR == TIMER_OFFSET && (&CFG_BE) && !PRELOAD_WR;
	a_reset_defaults: assert property ($past(RESET) |-> VGA_DECODE_EN && CUT_THRESHOLD == 2'h1
		&& !STORE_FORWARD && !ARB_HOLD) else $error("bad reset defaults");
	a_replay_fallback: assert property (!$past(RESET) && !REPLAY_USER_ACTIVE
		|-> REPLAY_TIMEOUT == $past(REPLAY_DEFAULT)) else $error("replay fallback wrong");
	a_ack_fallback: assert property (!$past(RESET) && !ACK_USER_ACTIVE
		|-> ACK_LATENCY == $past(ACK_DEFAULT)) else $error("ack fallback wrong");
	a_vga_read_only: assert property ($changed(VGA_DECODE_EN) |-> $past(PRELOAD_WR, 3))
		else $error("vga bit changed without preload");
	a_np_read_only: assert property ($changed(NONPOSTED_STORE_FORWARD) |-> $past(PRELOAD_WR, 3))
		else $error("nonposted bit changed without preload");
	a_mode_low_write: assert property (mode_wr |-> ##2
		{CUT_THRESHOLD, STORE_FORWARD} == $past(CFG_WDATA[2:0], 2)) else $error("forward mode wrong");
	a_mode_high_write: assert property (mode_wr |-> ##2 {CPL_TAG_ORDERING, EGRESS_ORDERING,
		CREDIT_ALL_TYPES, ARB_HOLD} == $past(CFG_WDATA[6:3], 2)) else $error("mode bits wrong");
	a_timer_enable: assert property (timer_wr |-> ##2 {ACK_USER_ACTIVE, REPLAY_USER_ACTIVE}
		== {$past(CFG_WDATA[30], 2), $past(CFG_WDATA[12], 2)}) else $error("timer enables wrong");
	a_preload_done: assert property (!$past(RESET) |-> PRELOAD_LOADED
		== ($past(PRELOAD_LOADED) || $past(PRELOAD_DONE))) else $error("loaded flag wrong");
	c_mode_write: cover property (mode_wr);
	c_timer_write: cover property (timer_wr ##2 REPLAY_USER_ACTIVE);
	c_preload: cover property ($rose(PRELOAD_LOADED));
endmodule : switch_forwarding_config_properties
`default_nettype wire

// file: tb/eeprom_loader_model.sv
// Behavioural EEPROM preload engine feeding default words
`timescale 1ns/10ps
`default_nettype none
module eeprom_loader_model
	import fwd_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic start,
	output logic wr,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] data,
	output logic done
);
	task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk) #1;
		wr = 1'h1;
		addr = a;
		data = d;
	endtask : put
	initial begin
		wr = 1'h0;
		done = 1'h0;
		addr = '0;
		data = '0;
		@(posedge start);
		put(MODE_OFFSET, 32'h00000080);
		put(TIMER_OFFSET, 32'h00006000);
		@(posedge clk) #1;
		wr = 1'h0;
		// Idle lines must not look like the last word
		addr = ~addr;
		data = ~data;
		done = 1'h1;
		@(posedge clk) #1;
		done = 1'h0;
	end
endmodule : eeprom_loader_model
`default_nettype wire

// file: tb/test_switch_forwarding_config.sv
// Self-checking bench for the forwarding configuration bank
`timescale 1ns/10ps
`default_nettype none
module test_switch_forwarding_config;
	import fwd_cfg_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [ADDR_W-1:0] addr = '0;
	logic [BE_W-1:0] be = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic rdv;
	logic start = 1'h0;
	logic pwr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pdata;
	logic pdone;
	logic loaded;
	logic [REPLAY_W-1:0] replay_def = 12'h5a5;
	logic [ACK_W-1:0] ack_def = 14'h2b3c;
	logic [REPLAY_W-1:0] replay_t;
	logic [ACK_W-1:0] ack_l;
	logic replay_on, ack_on, vga, sf, arb, credit, egress, tagord, npsf;
	logic [CUT_W-1:0] cut;
	logic pm_cap, msi_cap, rx_pol, cpl_par;
	logic [PM_PARAM_W-1:0] pm_par;
	logic [DRV_W-1:0] drv3, drv6, drvh;
	logic [DATA_W-1:0] phy_word;
	int fails = 0;
	int samples_checked = 0;
	localparam logic [DATA_W-1:0] mode_rst = MODE_RESET_BASE | (32'(PM_PARAM_RESET) << PM_PARAM_LSB);
	initial forever #5 clk = ~clk;
	eeprom_loader_model u_loader (.clk(clk), .start(start), .wr(pwr), .addr(paddr), .data(pdata),
		.done(pdone));
	switch_forwarding_config u_dut (.SYS_CLK(clk), .RESET(rst), .CFG_WR(wr), .CFG_RD(rd),
		.CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RDVALID(rdv),
		.PRELOAD_WR(pwr), .PRELOAD_ADDR(paddr), .PRELOAD_DATA(pdata), .PRELOAD_DONE(pdone),
		.PRELOAD_LOADED(loaded), .REPLAY_DEFAULT(replay_def), .ACK_DEFAULT(ack_def),
		.REPLAY_TIMEOUT(replay_t), .REPLAY_USER_ACTIVE(replay_on), .ACK_LATENCY(ack_l),
		.ACK_USER_ACTIVE(ack_on), .VGA_DECODE_EN(vga), .PM_CAP_DISABLE(pm_cap),
		.MSI_CAP_DISABLE(msi_cap),
		.STORE_FORWARD(sf), .CUT_THRESHOLD(cut), .ARB_HOLD(arb), .CREDIT_ALL_TYPES(credit),
		.EGRESS_ORDERING(egress), .CPL_TAG_ORDERING(tagord), .NONPOSTED_STORE_FORWARD(npsf),
		.PM_CONTROL_PARAM(pm_par), .RX_POLARITY_INV_DISABLE(rx_pol),
		.CPL_PARITY_DISABLE(cpl_par), .DRV_LVL_3P5(drv3),
		.DRV_LVL_6P0(drv6), .DRV_LVL_HALF(drvh), .PHY_TEST_WORD(phy_word));
	task automatic wrap_up();
		$display("samples_checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cwr(input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] b, input logic [DATA_W-1:0] d);
		@(posedge clk) #1;
		wr = 1'h1;
		addr = a;
		be = b;
		wdata = d;
		@(posedge clk) #1;
		wr = 1'h0;
	endtask : cwr
	task automatic crd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		int n;
		@(posedge clk) #1;
		rd = 1'h1;
		addr = a;
		@(posedge clk) #1;
		rd = 1'h0;
		n = 0;
		while (rdv !== 1'h1 && n < 4) begin
			@(posedge clk) #1;
			n++;
		end
		if (n == 4) begin
			fails++;
			$display("mismatch at %0t: no read answer", $time);
			wrap_up();
		end else chk(rdata, e, "read");
	endtask : crd
	// Derived outputs trail the stored word by a register stage
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	initial begin
		int n;
		repeat (6) @(posedge clk);
		#1 rst = 1'h0;
		crd(TEST_WORD_OFFSET, TEST_WORD_RESET);
		crd(TIMER_OFFSET, TIMER_RESET);
		crd(MODE_OFFSET, mode_rst);
		crd(8'h78, '0);
		chk(32'(replay_t), 32'(replay_def), "replay default");
		chk(phy_word, TEST_WORD_RESET, "test word out");
		chk(32'({drvh, drv6, drv3, cpl_par, rx_pol, pm_par}), 32'(mode_rst[30:8]), "phy defaults");
		cwr(TEST_WORD_OFFSET, 4'h5, 32'h12345678);
		settle();
		chk(phy_word, 32'h04340878, "test word lanes");
		$display("reset values done");
		cwr(TIMER_OFFSET, 4'hf, 32'hffffffff);
		crd(TIMER_OFFSET, TIMER_RW | (TIMER_RESET & ~TIMER_RW));
		settle();
		chk(32'({ack_on, ack_l, replay_on, replay_t}), 32'h0fffffff, "user timers");
		chk(32'({vga, msi_cap, pm_cap}), 32'h4, "read-only timer bits");
		cwr(TIMER_OFFSET, 4'h3, 32'h0);
		settle();
		chk(32'({ack_on, ack_l, replay_on, replay_t}), {4'h0, 15'h7fff, 1'h0, replay_def}, "replay off");
		replay_def = 12'h3c3;
		ack_def = 14'h1d2e;
		settle();
		chk(32'(replay_t), 32'(replay_def), "new replay default");
		cwr(TIMER_OFFSET, 4'hc, 32'h0);
		cwr(TIMER_OFFSET, 4'h2, 32'h00001a55);
		settle();
		chk(32'({ack_l, replay_on, replay_t}), {5'h0, ack_def, 1'h1, 12'ha00}, "byte lane");
		$display("timer tests done");
		for (int i = 0; i < 4; i++) begin
			cwr(MODE_OFFSET, 4'h1, 32'((i << 1) | (i & 1)));
			settle();
			chk(32'({cut, sf}), 32'((i << 1) | (i & 1)), "threshold");
		end
		cwr(MODE_OFFSET, 4'hf, 32'hffffffff);
		crd(MODE_OFFSET, MODE_RW | (mode_rst & ~MODE_RW));
		settle();
		chk(32'({npsf, tagord, egress, credit, arb, cut, sf}), 32'h7f, "mode bits");
		chk(32'(pm_par), 32'h3f, "pm param");
		cwr(MODE_OFFSET, 4'h1, 32'h0);
		settle();
		chk(32'({tagord, egress, credit, arb}), 32'h0, "mode clear");
		cwr(8'h78, 4'hf, 32'hffffffff);
		crd(8'h78, '0);
		$display("mode tests done");
		start = 1'h1;
		n = 0;
		while (loaded !== 1'h1 && n < 50) begin
			@(posedge clk) #1;
			n++;
		end
		if (loaded !== 1'h1) begin
			fails++;
			$display("mismatch at %0t: preload never finished", $time);
			wrap_up();
		end
		settle();
		crd(MODE_OFFSET, 32'h00000080);
		crd(TIMER_OFFSET, 32'h00006000);
		chk(32'({vga, msi_cap, pm_cap, npsf}), 32'h7, "preloaded outputs");
		chk(32'({drvh, drv6, drv3, cpl_par, rx_pol, pm_par}), 32'h0, "preloaded phy");
		cwr(MODE_OFFSET, 4'hf, 32'hffffffff);
		crd(MODE_OFFSET, MODE_RW | 32'h00000080);
		$display("preload tests done");
		@(posedge clk) #1;
		rst = 1'h1;
		repeat (2) @(posedge clk);
		#1 rst = 1'h0;
		crd(TIMER_OFFSET, TIMER_RESET);
		chk(32'(loaded), 32'h0, "loaded after reset");
		$display("second reset done");
		wrap_up();
	end
endmodule : test_switch_forwarding_config
bind switch_forwarding_config switch_forwarding_config_properties u_props (.*);
`default_nettype wire
